// *** tdc_dev.sv ***
// device end: counter, control latches, parity check, external words
// assumes switch and window inputs arrive from other logic on clock_i
`timescale 1ns/10ps
`include "tdc_consts.svh"
module tdc_dev (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // external word path
  tdc_if.dev        ext,
  // panel, machine check and interval timer
  output logic      invalid_lamp_o,
  output logic      mck_summary_o,
  output logic      mck_req_o,
  output logic      itmr_o
);
  logic [51:0]     cnt_ff;
  logic [31:0]     hold_hi_ff;
  logic [31:0]     hold_lo_ff;
  logic            run_ff;
  logic            set_ff;
  logic            err_ff;
  logic            runbit_ff;
  logic            ldh_ff;
  logic            ldl_ff;
  logic            check_ff;
  logic            mhz_pend_ff;
  logic [6:0]      pred_ff;
  logic            pon_ff;
  logic [31:0]     wval;
  logic            wr_ok;
  logic            mhz;
  logic            adv;
  tdc_pkg::tdc_upd_t upd_ff;

  tdc_osc u_osc (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .mhz_o   (mhz),
    .itmr_o  (itmr_o)
  );

  function automatic logic [6:0] byte_par(input logic [51:0] v);
    logic [6:0] p;
    p = 7'h00;
    for (int i = 0; i < 7; i++) begin
      p[i] = ^(v >> (8 * i) & 52'hff);
    end
    return p;
  endfunction : byte_par

  function automatic logic [51:0] incr(input logic [51:0] v);
    return v + 52'h1;
  endfunction : incr

  // a byte write fills every byte of the word
  assign wval  = ext.byte_mode ? {4{ext.wdata[7:0]}} : ext.wdata;
  // refused while running, or with secure switch outside power-on
  assign wr_ok = !runbit_ff && !run_ff && (ext.switch_enable || pon_ff);
  // advance only inside the cpu timing window
  assign adv   = mhz_pend_ff && ext.cycle_window && run_ff && (upd_ff == tdc_pkg::TDC_IDLE);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mhz_pend_ff <= 1'b0;
    end else if (mhz) begin
      mhz_pend_ff <= 1'b1;
    end else if (adv) begin
      mhz_pend_ff <= 1'b0;
    end
  end

  // power-on routine window ends with its own start
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pon_ff <= 1'b1;
    end else if (run_ff) begin
      pon_ff <= 1'b0;
    end else if (ext.power_on) begin
      pon_ff <= 1'b1;
    end
  end

  // control latches and the set interlock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      runbit_ff <= 1'b0;
      run_ff    <= 1'b0;
      set_ff    <= 1'b0;
      ldh_ff    <= 1'b0;
      ldl_ff    <= 1'b0;
    end else begin
      if (ext.wr && ext.addr == `TDC_ADDR_LOW && (ext.switch_enable || pon_ff)
          && !wval[`TDC_BIT_RUN]) begin
        runbit_ff <= 1'b0;
        run_ff    <= 1'b0;
        set_ff    <= 1'b0;
        ldh_ff    <= 1'b0;
        ldl_ff    <= 1'b0;
      end else if (ext.wr && wr_ok && ext.addr == `TDC_ADDR_HIGH) begin
        ldh_ff <= 1'b1;
      end else if (ext.wr && wr_ok && ext.addr == `TDC_ADDR_LOW) begin
        ldl_ff <= 1'b1;
      end else if (ldh_ff && ldl_ff) begin
        runbit_ff <= 1'b1;
        run_ff    <= 1'b1;
        set_ff    <= !pon_ff;
        ldh_ff    <= 1'b0;
        ldl_ff    <= 1'b0;
      end
      if (check_ff) begin
        set_ff <= 1'b0;
      end
    end
  end

  // counter load and advance through the strobe chain
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff   <= 52'h0;
      upd_ff   <= tdc_pkg::TDC_IDLE;
      pred_ff  <= 7'h00;
      check_ff <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      if (check_ff) begin
        check_ff <= 1'b0;
      end
      if (ext.wr && wr_ok && ext.addr == `TDC_ADDR_HIGH) begin
        cnt_ff[51:20] <= wval;
      end else if (ext.wr && wr_ok && ext.addr == `TDC_ADDR_LOW) begin
        cnt_ff[19:0] <= wval[`TDC_CNT_LOW_MSB:`TDC_CNT_LOW_LSB];
        err_ff       <= 1'b0;
      end
      case (upd_ff)
        tdc_pkg::TDC_IDLE: begin
          if (adv) begin
            upd_ff <= tdc_pkg::TDC_STRB1;
          end
        end
        tdc_pkg::TDC_STRB1: begin
          pred_ff <= byte_par(incr(cnt_ff));
          upd_ff  <= tdc_pkg::TDC_STRB2;
        end
        tdc_pkg::TDC_STRB2: begin
          // a clear that lands mid-update drops the step, so a load on this edge wins
          if (run_ff) begin
            cnt_ff <= incr(cnt_ff);
            upd_ff <= tdc_pkg::TDC_STRB3;
          end else begin
            upd_ff <= tdc_pkg::TDC_IDLE;
          end
        end
        tdc_pkg::TDC_STRB3: begin
          if (byte_par(cnt_ff) != pred_ff) begin
            check_ff <= 1'b1;
            err_ff   <= 1'b1;
          end
          upd_ff <= tdc_pkg::TDC_STRB4;
        end
        tdc_pkg::TDC_STRB4: begin
          upd_ff <= tdc_pkg::TDC_IDLE;
        end
        default: begin
          upd_ff <= tdc_pkg::TDC_IDLE;
        end
      endcase
    end
  end

  // holding latches: refreshed only when no read is in progress
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_hi_ff <= 32'h0;
      hold_lo_ff <= 32'h0;
    end else if (!ext.rd) begin
      hold_hi_ff <= cnt_ff[51:20];
      hold_lo_ff <= {cnt_ff[19:0], 4'h0, runbit_ff, ext.switch_enable,
                     runbit_ff && set_ff && !err_ff, `TDC_CPU_ID};
    end
  end

  // read path, one cycle after rd
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext.rdata <= 32'h0;
    end else if (ext.rd && ext.addr == `TDC_ADDR_HIGH) begin
      ext.rdata <= hold_hi_ff;
    end else if (ext.rd && ext.addr == `TDC_ADDR_LOW) begin
      ext.rdata <= hold_lo_ff;
    end else if (ext.rd) begin
      ext.rdata <= 32'h0;
    end
  end

  // outputs: write-through check and panel indication
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext.wr_check_err <= 1'b0;
      invalid_lamp_o   <= 1'b1;
      mck_summary_o    <= 1'b0;
      mck_req_o        <= 1'b0;
    end else begin
      // a write refused while running is expected, not an error
      ext.wr_check_err <= ext.wr && !wr_ok && !runbit_ff && !run_ff;
      invalid_lamp_o   <= !(runbit_ff && set_ff && !err_ff);
      mck_req_o        <= check_ff;
      if (check_ff) begin
        mck_summary_o <= 1'b1;
      end
    end
  end
endmodule : tdc_dev

// *** tdc_consts.svh ***
// constants for the time-of-day counter: addresses, bit positions, timing
// assumes a 100 MHz system clock and 32-bit external words
`ifndef TDC_CONSTS_SVH
`define TDC_CONSTS_SVH
`define TDC_ADDR_HIGH      8'h36
`define TDC_ADDR_LOW       8'h3e
`define TDC_BIT_RUN        7
`define TDC_BIT_SWITCH     6
`define TDC_BIT_VALID      5
`define TDC_IDENT_HI       4
`define TDC_IDENT_LO       0
`define TDC_CNT_LOW_MSB    31
`define TDC_CNT_LOW_LSB    12
`define TDC_LOW_LSB_INC    20'h00001
`define TDC_CLK_MHZ        100
`define TDC_US_CYCLES      (`TDC_CLK_MHZ)
`define TDC_IT_NS          13252
`define TDC_IT_CYCLES      ((`TDC_IT_NS * `TDC_CLK_MHZ) / 1000)
`define TDC_WIN_LO         90
`define TDC_WIN_HI         135
`define TDC_WIN_PERIOD     200
`define TDC_CPU_ID         5'h0a
`define TDC_BYTE_REPL      8'h00
`define TDC_RD_LAT         1
`endif

// *** tdc_pkg.sv ***
// types for the time-of-day counter; only the device end uses any of them
// assumes tdc_consts.svh is available
package tdc_pkg;
  typedef enum logic [4:0] {
    TDC_IDLE  = 5'b00001,
    TDC_STRB1 = 5'b00010,
    TDC_STRB2 = 5'b00100,
    TDC_STRB3 = 5'b01000,
    TDC_STRB4 = 5'b10000
  } tdc_upd_t;
  typedef enum logic [3:0] {
    TDC_H_IDLE = 4'b0001,
    TDC_H_WR   = 4'b0010,
    TDC_H_RD   = 4'b0100,
    TDC_H_DATA = 4'b1000
  } tdc_host_t;
endpackage : tdc_pkg

// *** tdc_if.sv ***
// external word path between microcode processor and the counter
// assumes one shared clock; read data is valid one cycle after rd
`timescale 1ns/10ps
interface tdc_if;
  logic        wr;
  logic        rd;
  logic        byte_mode;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr_check_err;
  logic        cycle_window;
  logic        switch_enable;
  logic        power_on;
  modport dev  (input wr, rd, byte_mode, addr, wdata, cycle_window, switch_enable, power_on,
                output rdata, wr_check_err);
  modport host (output wr, rd, byte_mode, addr, wdata, cycle_window, power_on,
                input rdata, wr_check_err, switch_enable);
endinterface : tdc_if

// *** tdc_osc.sv ***
// oscillator divider: 1 MHz and interval-timer enable pulses
// assumes the 100 MHz system clock
`timescale 1ns/10ps
`include "tdc_consts.svh"
module tdc_osc (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // enables
  output logic      mhz_o,
  output logic      itmr_o
);
  logic [7:0]  us_ff;
  logic [15:0] it_ff;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      us_ff <= 8'h00;
      mhz_o <= 1'b0;
    end else begin
      mhz_o <= (us_ff == 8'(`TDC_US_CYCLES - 1));
      us_ff <= (us_ff == 8'(`TDC_US_CYCLES - 1)) ? 8'h00 : us_ff + 8'h01;
    end
  end
  // about 75.46 kHz, rounded down to whole cycles
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      it_ff  <= 16'h0000;
      itmr_o <= 1'b0;
    end else begin
      itmr_o <= (it_ff == 16'(`TDC_IT_CYCLES - 1));
      it_ff  <= (it_ff == 16'(`TDC_IT_CYCLES - 1)) ? 16'h0000 : it_ff + 16'h0001;
    end
  end
endmodule : tdc_osc

// *** tdc_host.sv ***
// microcode end: issues external writes and reads, forms cpu timing window
// assumes software port: addr, wdata, wr, rd; read data three cycles later
`timescale 1ns/10ps
`include "tdc_consts.svh"
module tdc_host (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // software port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        byte_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        power_on_i,
  output logic [31:0]      rdata_o,
  output logic             check_o,
  // external word path
  tdc_if.host              ext
);
  logic [7:0] win_ff;
  // cpu timing window 90-135 of each 200 ns cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      win_ff           <= 8'h00;
      ext.cycle_window <= 1'b0;
    end else begin
      win_ff <= (win_ff == 8'(`TDC_WIN_PERIOD - 10)) ? 8'h00 : win_ff + 8'h0a;
      ext.cycle_window <= (win_ff >= 8'(`TDC_WIN_LO)) && (win_ff <= 8'(`TDC_WIN_HI));
    end
  end
  // set order (clear low, high, low with run bit) is kept by software
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext.wr        <= 1'b0;
      ext.rd        <= 1'b0;
      ext.byte_mode <= 1'b0;
      ext.addr      <= 8'h00;
      ext.wdata     <= 32'h0;
      ext.power_on  <= 1'b0;
    end else begin
      ext.wr        <= wr_i;
      ext.rd        <= rd_i;
      ext.byte_mode <= byte_i;
      ext.addr      <= addr_i;
      ext.wdata     <= wdata_i;
      ext.power_on  <= power_on_i;
    end
  end
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0;
      check_o <= 1'b0;
    end else begin
      rdata_o <= ext.rdata;
      check_o <= ext.wr_check_err;
    end
  end
endmodule : tdc_host

// *** tdc_assertions.sv ***
// checker on the external word path between the two ends
// assumes one clock; instanced beside the interface by the bench
`timescale 1ns/10ps
`include "tdc_consts.svh"
module tdc_assertions (
  // clock and reset
  input wire logic        clock_i,
  input wire logic        nrst_i,
  // external word path
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  addr,
  input wire logic [31:0] rdata,
  input wire logic        wr_check_err,
  input wire logic        cycle_window,
  input wire logic        switch_enable
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  strobe_excl_a:
    assert property (!(wr && rd)) else $error("write and read strobes together");
  win_period_a:
    assert property ($rose(cycle_window) |-> ##20 $rose(cycle_window)) else $error("window period wrong");
  win_width_a:
    assert property ($rose(cycle_window) |-> ##[3:6] $fell(cycle_window)) else $error("window width wrong");
  rd_hold_a:
    assert property (!$past(rd) |-> $stable(rdata)) else $error("read data moved without a read");
  low_zero_a:
    assert property ($past(rd) && $past(addr) == `TDC_ADDR_LOW |-> rdata[11:8] == 4'h0 && rdata[4:0] == `TDC_CPU_ID)
      else $error("low word spare or id bits wrong");
  switch_bit_a:
    assert property ($past(rd) && $past(addr) == `TDC_ADDR_LOW |-> rdata[6] == $past(switch_enable, 2))
      else $error("switch bit does not follow switch");
  valid_run_a:
    assert property ($past(rd) && $past(addr) == `TDC_ADDR_LOW && rdata[5] |-> rdata[7])
      else $error("valid without running");
  err_cause_a:
    assert property (wr_check_err |-> ($past(wr) || $past(wr, 2)) && !$past(switch_enable) ##1 !wr_check_err)
      else $error("write check error without cause");
endmodule : tdc_assertions

// *** testbench.sv ***
// self-checking bench: host and device ends joined by one interface
// assumes the software port of the host end; switch driven here
`timescale 1ns/10ps
`include "tdc_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [31:0] rv;
  logic        clock_i, nrst_i, byte_i, wr_i, rd_i, power_on_i, check_o;
  logic        invalid_lamp_o, mck_summary_o, mck_req_o, itmr_o;
  int          n_errors, n_checks, n_pulse, n_mck, n_flag, n;
  tdc_if ext_if ();
  tdc_dev tdc_dev_i (.clock_i(clock_i), .nrst_i(nrst_i), .ext(ext_if.dev), .invalid_lamp_o(invalid_lamp_o),
    .mck_summary_o(mck_summary_o), .mck_req_o(mck_req_o), .itmr_o(itmr_o));
  tdc_host tdc_host_i (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .byte_i(byte_i),
    .wr_i(wr_i), .rd_i(rd_i), .power_on_i(power_on_i), .rdata_o(rdata_o), .check_o(check_o), .ext(ext_if.host));
  tdc_assertions tdc_assertions_i (.clock_i(clock_i), .nrst_i(nrst_i), .wr(ext_if.wr), .rd(ext_if.rd),
    .addr(ext_if.addr), .rdata(ext_if.rdata), .wr_check_err(ext_if.wr_check_err),
    .cycle_window(ext_if.cycle_window), .switch_enable(ext_if.switch_enable));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (ext_if.wr_check_err === 1'b1) n_pulse++;
    if (mck_req_o === 1'b1) n_mck++;
    if (check_o === 1'b1) n_flag++;
  end
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d, input logic b);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    byte_i  <= b;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr_word
  // read data lands three edges after the strobe; one spare edge for margin
  task automatic rd_word(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1 rv = rdata_o;
  endtask : rd_word
  task automatic set_switch(input logic v);
    @(posedge clock_i);
    ext_if.switch_enable <= v;
  endtask : set_switch
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  initial begin
    nrst_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    byte_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    power_on_i = 1'b0;
    ext_if.switch_enable = 1'b0;
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    power_on_i <= 1'b1;
    // power-on start needs neither switch nor clearing write
    wr_word(`TDC_ADDR_HIGH, 32'h0, 1'b0);
    wr_word(`TDC_ADDR_LOW, 32'h0000_0080, 1'b0);
    @(posedge clock_i);
    power_on_i <= 1'b0;
    rd_word(`TDC_ADDR_LOW);
    `CHK(rv[11:0], {4'h0, 3'b100, `TDC_CPU_ID})
    `CHK(invalid_lamp_o, 1'b1)
    repeat (500) @(posedge clock_i);
    rd_word(`TDC_ADDR_LOW);
    `CHK(rv[31:12] >= 20'h4 && rv[31:12] <= 20'h6, 1'b1)
    set_switch(1'b1);
    wr_word(`TDC_ADDR_HIGH, 32'h1234_5678, 1'b0);
    wr_word(8'h40, 32'h0, 1'b0);
    rd_word(`TDC_ADDR_HIGH);
    `CHK(rv, 32'h0)
    `CHK(n_pulse, 0)
    `CHK(n_flag, 0)
    set_switch(1'b0);
    wr_word(`TDC_ADDR_LOW, 32'h0, 1'b1);
    rd_word(`TDC_ADDR_LOW);
    `CHK(rv[7:6], 2'b10)
    set_switch(1'b1);
    wr_word(`TDC_ADDR_LOW, 32'h0, 1'b1);
    rd_word(`TDC_ADDR_LOW);
    `CHK(rv[7:5], 3'b010)
    set_switch(1'b0);
    wr_word(`TDC_ADDR_HIGH, 32'h5, 1'b0);
    repeat (4) @(posedge clock_i);
    `CHK(n_pulse, 1)
    `CHK(n_flag, 1)
    set_switch(1'b1);
    wr_word(`TDC_ADDR_HIGH, 32'h0000_00ff, 1'b1);
    wr_word(`TDC_ADDR_LOW, 32'h0000_0080, 1'b1);
    rd_word(`TDC_ADDR_HIGH);
    `CHK(rv, 32'hffff_ffff)
    rd_word(`TDC_ADDR_LOW);
    `CHK(rv[7:5], 3'b111)
    `CHK(rv[31:12] >= 20'h80808 && rv[31:12] <= 20'h8080a, 1'b1)
    `CHK(invalid_lamp_o, 1'b0)
    wr_word(`TDC_ADDR_LOW, 32'h0, 1'b1);
    wr_word(`TDC_ADDR_HIGH, 32'hffff_ffff, 1'b0);
    wr_word(`TDC_ADDR_LOW, 32'hffff_f080, 1'b0);
    repeat (300) @(posedge clock_i);
    rd_word(`TDC_ADDR_HIGH);
    `CHK(rv, 32'h0)
    repeat (1400) begin
      @(posedge clock_i);
      if (itmr_o === 1'b1) break;
    end
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (itmr_o !== 1'b1 && n < 2000);
    `CHK(n, `TDC_IT_CYCLES)
    `CHK(n_mck, 0)
    `CHK(mck_summary_o, 1'b0)
    complete_run();
  end
endmodule : testbench
